// *** wfr_consts.vh ***
// Constants for the watchdog and frequency-recovery control block
`ifndef WFR_CONSTS_VH
`define WFR_CONSTS_VH

`define WFR_CLK_HZ          20000000
`define WFR_TICK_SHORT_MS   150
`define WFR_TICK_LONG_DS    25
`define WFR_RST_PULSE_CYC   64
`define WFR_SMB_ADDR        7'h69

`define WFR_IDX_CTRL        8'h00
`define WFR_IDX_SPEED       8'h01
`define WFR_IDX_CPU_N       8'h02
`define WFR_IDX_CPU_M       8'h03
`define WFR_IDX_REC_CTRL    8'h04
`define WFR_IDX_WD_COUNT    8'h05
`define WFR_IDX_REC_N       8'h06
`define WFR_IDX_REC_M       8'h07
`define WFR_IDX_STATUS      8'h08

`define WFR_CTRL_PROG_EN    0
`define WFR_CTRL_PRIO       1
`define WFR_RC_SRC          0
`define WFR_RC_WATCHDOG_RUN_ENABLE        1
`define WFR_RC_EXPIRED      2
`define WFR_RC_TICK         3
`define WFR_RC_RST_WD       4
`define WFR_RC_RST_FC       5
`define WFR_RC_REC_ACT      6
`define WFR_ST_RUNNING      7

`define WFR_RST_CTRL        2'h0
`define WFR_RST_SPEED       5'h00
`define WFR_RST_CPU_N       8'h00
`define WFR_RST_CPU_M       7'h00
`define WFR_RST_REC_N       8'h00
`define WFR_RST_REC_M       7'h00
`define WFR_RST_WD_COUNT    5'h00

`endif

// *** wfr_watchdog_timeout_count.v ***
// Watchdog tick divider and countdown timer
`timescale 1ns/1ps
`include "wfr_consts.vh"

module wfr_watchdog_timeout_count #(
    parameter PW          = 26,
    parameter SHORT_CYC   = 3000000,
    parameter LONG_CYC    = 50000000
) (
    input  wire          ref_clk,
    input  wire          rstn,
    input  wire          run_enable,
    input  wire          tick_unit,
    input  wire [4:0]    timeout_count,
    input  wire          start,
    output reg           timeout_pulse,
    output reg  [4:0]    remain_reg,
    output reg           running_reg
);

    localparam integer  SHORT_M1  = SHORT_CYC - 1;
    localparam integer  LONG_M1   = LONG_CYC - 1;
    localparam [PW-1:0] SHORT_LIM = SHORT_M1[PW-1:0];
    localparam [PW-1:0] LONG_LIM  = LONG_M1[PW-1:0];

    reg  [PW-1:0] pre_reg;
    wire [PW-1:0] pre_lim = tick_unit ? LONG_LIM : SHORT_LIM;
    wire          tick    = running_reg && (pre_reg == pre_lim);

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pre_reg       <= {PW{1'b0}};
            remain_reg    <= `WFR_RST_WD_COUNT;
            running_reg   <= 1'b0;
            timeout_pulse <= 1'b0;
        end
        else
        begin
            timeout_pulse <= 1'b0;
            if (!run_enable)
            begin
                // Stopped and held at the programmed count
                running_reg <= 1'b0;
                pre_reg     <= {PW{1'b0}};
                remain_reg  <= timeout_count;
            end
            else if (start)
            begin
                // Armed timer only begins after a frequency change
                running_reg <= 1'b1;
                pre_reg     <= {PW{1'b0}};
                remain_reg  <= timeout_count;
            end
            else if (!running_reg)
            begin
                pre_reg    <= {PW{1'b0}};
                remain_reg <= timeout_count;
            end
            else if (tick)
            begin
                pre_reg <= {PW{1'b0}};
                // Count k expires after k+1 units
                if (remain_reg == 5'h00)
                begin
                    running_reg   <= 1'b0;
                    timeout_pulse <= 1'b1;
                end
                else
                    remain_reg <= remain_reg - 5'h01;
            end
            else
                pre_reg <= pre_reg + {{(PW-1){1'b0}}, 1'b1};
        end
    end

endmodule

// *** wfr_watchdog_ctrl.v ***
// SMBus register slave, frequency selection and watchdog recovery control
`timescale 1ns/1ps
`include "wfr_consts.vh"

// How it works
// - On timeout the CPU clock switches itself to the recovery setting.
// - Recovery source 0 uses latched strap code, 1 uses recovery N and M.
// - Recovery from N/M uses 8-bit recovery N and 7-bit recovery M.
// - Strap recovery ratio code is always the latched strap code, whatever the priority bit.
// - Writing either recovery N or M during N/M recovery starts a new recovery load.
// - Watchdog enable 0 stops the counter and reloads the count.
// - Enabled counter waits for a frequency change, then counts down.
// - Timeout flag reads 1 after timeout; write 1 clears, 0 ignored.
// - Five-bit timeout count, unit chosen by the tick-unit bit.
// - A tick while the counter is at zero sets the timeout flag.
// - Tick unit 0 is 150 ms, spanning 150 ms to 4.8 s.
// - Tick unit 1 is 2.5 s, spanning 2.5 s to 80 s.
// - Reset-on-timeout enable gives a reset pulse on each timeout.
// - Reset-on-frequency-change enable gives a reset pulse after changes.
// - Programmable mode: frequency is gear times (N+3)/(M+3).
// - Gear constant chosen by strap or programmed code per priority bit.
// - Programmable mode off: frequency code from strap or programmed code.
// - Programmable mode uses CPU N and M; either write starts loading.
module wfr_watchdog_ctrl #(
    parameter [6:0] SMB_ADDR  = `WFR_SMB_ADDR,
    parameter       SHORT_CYC = `WFR_TICK_SHORT_MS * (`WFR_CLK_HZ / 1000),
    parameter       LONG_CYC  = `WFR_TICK_LONG_DS * (`WFR_CLK_HZ / 10),
    parameter       RST_CYC   = `WFR_RST_PULSE_CYC
) (
    input  wire          ref_clk,
    input  wire          rstn,
    input  wire          smb_sclk,
    input  wire          smb_sdata_i,
    output wire          smb_sdata_o,
    output reg           smb_sdata_oe,
    input  wire [4:0]    strap_speed_code,
    output reg  [8:0]    pll_fb_div,
    output reg  [7:0]    pll_ref_div,
    output reg  [4:0]    pll_speed_code,
    output reg           pll_use_nm,
    output reg           pll_load,
    output reg           sys_rst_n
);

    localparam [3:0] S_IDLE  = 4'h0;
    localparam [3:0] S_ADDR  = 4'h1;
    localparam [3:0] S_CMD   = 4'h2;
    localparam [3:0] S_WDATA = 4'h3;
    localparam [3:0] S_ACK   = 4'h4;
    localparam [3:0] S_RDATA = 4'h5;
    localparam [3:0] S_RACK  = 4'h6;
    localparam [3:0] S_WAIT  = 4'h7;
    localparam [7:0] RCW     = RST_CYC[7:0];

    // Pin synchronisers; the third stage only feeds edge detection
    reg  [2:0] scl_s;
    reg  [2:0] sda_s;
    reg  [4:0] strap_s1;
    reg  [4:0] strap_s2;
    wire       scl_rise = scl_s[1] & ~scl_s[2];
    wire       scl_fall = ~scl_s[1] & scl_s[2];
    wire       sda_bit  = sda_s[1];
    wire       start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
    wire       stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_s    <= 3'h7;
            sda_s    <= 3'h7;
            strap_s1 <= 5'h00;
            strap_s2 <= 5'h00;
        end
        else
        begin
            scl_s    <= {scl_s[1:0], smb_sclk};
            sda_s    <= {sda_s[1:0], smb_sdata_i};
            strap_s1 <= strap_speed_code;
            strap_s2 <= strap_s1;
        end
    end

    // Straps are caught once, a few clocks after reset release
    reg [1:0] strap_cnt_reg;
    reg [4:0] strap_latch_reg;
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            strap_cnt_reg   <= 2'h0;
            strap_latch_reg <= 5'h00;
        end
        else if (strap_cnt_reg != 2'h3)
        begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == 2'h2)
                strap_latch_reg <= strap_s2;
        end
    end

    // Register file
    reg  [1:0] ctrl_reg;
    reg  [4:0] speed_reg;
    reg  [7:0] cpu_n_reg;
    reg  [6:0] cpu_m_reg;
    reg  [7:0] rec_n_reg;
    reg  [6:0] rec_m_reg;
    reg  [4:0] wd_count_reg;
    reg        rec_src_reg;
    reg        watchdog_run_enable_reg;
    reg        tick_unit_reg;
    reg        rst_watchdog_run_enable_reg;
    reg        rst_fc_en_reg;
    reg        expired_reg;
    reg        rec_act_reg;
    reg        wr_stb;
    reg  [7:0] wr_idx;
    reg  [7:0] wr_dat;
    wire       wd_timeout;
    wire [4:0] wd_remain;
    wire       wd_running;

    wire wr_freq = wr_stb && (wr_idx == `WFR_IDX_CTRL ||
                   wr_idx == `WFR_IDX_SPEED || wr_idx == `WFR_IDX_CPU_N ||
                   wr_idx == `WFR_IDX_CPU_M);
    // Recovery N/M writes reload only while that setting drives the clock
    wire wr_rec  = wr_stb && rec_act_reg && rec_src_reg &&
                   (wr_idx == `WFR_IDX_REC_N ||
                    wr_idx == `WFR_IDX_REC_M);
    wire sw_change = wr_freq | wr_rec;
    wire recover   = wd_timeout;
    // Flipping the source mid-recovery moves the clock, so it loads too
    wire src_flip = wr_stb && rec_act_reg &&
                    (wr_idx == `WFR_IDX_REC_CTRL) &&
                    (wr_dat[`WFR_RC_SRC] != rec_src_reg);
    wire freq_change = sw_change | recover | src_flip;
    wire clr_expired = wr_stb && (wr_idx == `WFR_IDX_REC_CTRL) &&
                       wr_dat[`WFR_RC_EXPIRED];

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_reg      <= `WFR_RST_CTRL;
            speed_reg     <= `WFR_RST_SPEED;
            cpu_n_reg     <= `WFR_RST_CPU_N;
            cpu_m_reg     <= `WFR_RST_CPU_M;
            rec_n_reg     <= `WFR_RST_REC_N;
            rec_m_reg     <= `WFR_RST_REC_M;
            wd_count_reg  <= `WFR_RST_WD_COUNT;
            rec_src_reg   <= 1'b0;
            watchdog_run_enable_reg     <= 1'b0;
            tick_unit_reg <= 1'b0;
            rst_watchdog_run_enable_reg <= 1'b0;
            rst_fc_en_reg <= 1'b0;
            expired_reg   <= 1'b0;
            rec_act_reg   <= 1'b0;
        end
        else
        begin
            if (wr_stb)
            begin
                case (wr_idx)
                    `WFR_IDX_CTRL:     ctrl_reg     <= wr_dat[1:0];
                    `WFR_IDX_SPEED:    speed_reg    <= wr_dat[4:0];
                    `WFR_IDX_CPU_N:    cpu_n_reg    <= wr_dat;
                    `WFR_IDX_CPU_M:    cpu_m_reg    <= wr_dat[6:0];
                    `WFR_IDX_REC_N:    rec_n_reg    <= wr_dat;
                    `WFR_IDX_REC_M:    rec_m_reg    <= wr_dat[6:0];
                    `WFR_IDX_WD_COUNT: wd_count_reg <= wr_dat[4:0];
                    `WFR_IDX_REC_CTRL:
                    begin
                        rec_src_reg   <= wr_dat[`WFR_RC_SRC];
                        watchdog_run_enable_reg     <= wr_dat[`WFR_RC_WATCHDOG_RUN_ENABLE];
                        tick_unit_reg <= wr_dat[`WFR_RC_TICK];
                        rst_watchdog_run_enable_reg <= wr_dat[`WFR_RC_RST_WD];
                        rst_fc_en_reg <= wr_dat[`WFR_RC_RST_FC];
                    end
                    default: ;
                endcase
            end
            // A timeout in the clearing cycle keeps the flag set
            expired_reg <= wd_timeout | (expired_reg & ~clr_expired);
            // Software taking back the clock ends recovery
            if (recover)
                rec_act_reg <= 1'b1;
            else if (wr_freq)
                rec_act_reg <= 1'b0;
        end
    end

    wfr_watchdog_timeout_count #(
        .PW        (26),
        .SHORT_CYC (SHORT_CYC),
        .LONG_CYC  (LONG_CYC)
    ) u_timer (
        .ref_clk       (ref_clk),
        .rstn          (rstn),
        .run_enable    (watchdog_run_enable_reg),
        .tick_unit     (tick_unit_reg),
        .timeout_count (wd_count_reg),
        .start         (sw_change),
        .timeout_pulse (wd_timeout),
        .remain_reg    (wd_remain),
        .running_reg   (wd_running)
    );

    // Clock selection; ratio and gear code follow the priority bit, except strap recovery which always takes the strap code
    wire [4:0] code_sel = ctrl_reg[`WFR_CTRL_PRIO] ? speed_reg
                                                   : strap_latch_reg;
    reg  [8:0] fb_next;
    reg  [7:0] ref_next;
    reg  [4:0] code_next;
    reg        nm_next;
    always @*
    begin
        fb_next   = {1'b0, cpu_n_reg} + 9'h003;
        ref_next  = {1'b0, cpu_m_reg} + 8'h03;
        code_next = code_sel;
        nm_next   = ctrl_reg[`WFR_CTRL_PROG_EN];
        if (rec_act_reg)
        begin
            if (rec_src_reg)
            begin
                fb_next   = {1'b0, rec_n_reg} + 9'h003;
                ref_next  = {1'b0, rec_m_reg} + 8'h03;
                code_next = code_sel;
                nm_next   = 1'b1;
            end
            else
            begin
                code_next = strap_latch_reg;
                nm_next   = 1'b0;
            end
        end
    end

    // Load strobe and new settings leave the same clock edge together
    reg chg_d_reg;
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pll_fb_div     <= 9'h003;
            pll_ref_div    <= 8'h03;
            pll_speed_code <= 5'h00;
            pll_use_nm     <= 1'b0;
            chg_d_reg      <= 1'b0;
            pll_load       <= 1'b0;
        end
        else
        begin
            pll_fb_div     <= fb_next;
            pll_ref_div    <= ref_next;
            pll_speed_code <= code_next;
            pll_use_nm     <= nm_next;
            chg_d_reg      <= freq_change;
            pll_load       <= chg_d_reg;
        end
    end

    // System reset pulse; a new trigger restarts the full width
    reg [7:0] rst_cnt_reg;
    wire rst_trig = (wd_timeout & rst_watchdog_run_enable_reg) |
                    (freq_change & rst_fc_en_reg);
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_cnt_reg <= 8'h00;
            sys_rst_n   <= 1'b1;
        end
        else
        begin
            if (rst_trig)
                rst_cnt_reg <= RCW;
            else if (rst_cnt_reg != 8'h00)
                rst_cnt_reg <= rst_cnt_reg - 8'h01;
            sys_rst_n <= ~(rst_trig | (rst_cnt_reg > 8'h01));
        end
    end

    // Read mux
    reg [7:0] rd_data;
    reg [7:0] idx_reg;
    always @*
    begin
        rd_data = 8'h00;
        case (idx_reg)
            `WFR_IDX_CTRL:     rd_data = {6'h00, ctrl_reg};
            `WFR_IDX_SPEED:    rd_data = {3'h0, speed_reg};
            `WFR_IDX_CPU_N:    rd_data = cpu_n_reg;
            `WFR_IDX_CPU_M:    rd_data = {1'b0, cpu_m_reg};
            `WFR_IDX_REC_N:    rd_data = rec_n_reg;
            `WFR_IDX_REC_M:    rd_data = {1'b0, rec_m_reg};
            `WFR_IDX_WD_COUNT: rd_data = {3'h0, wd_count_reg};
            `WFR_IDX_REC_CTRL: rd_data = {1'b0, rec_act_reg, rst_fc_en_reg,
                                          rst_watchdog_run_enable_reg, tick_unit_reg,
                                          expired_reg, watchdog_run_enable_reg,
                                          rec_src_reg};
            `WFR_IDX_STATUS:   rd_data = {wd_running, 2'h0, wd_remain};
            default:           rd_data = 8'h00;
        endcase
    end

    // SMBus slave: byte and sequential write/read with auto-increment
    reg [3:0] st_reg;
    reg [2:0] bit_cnt;
    reg [7:0] sh_reg;
    reg [7:0] tx_reg;
    reg       byte_full;
    reg       read_mode;
    reg       cmd_seen;

    assign smb_sdata_o = 1'b0;

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_reg <= S_IDLE;
            bit_cnt <= 3'h0;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            byte_full <= 1'b0;
            read_mode <= 1'b0;
            cmd_seen <= 1'b0;
            idx_reg <= 8'h00;
            smb_sdata_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_idx <= 8'h00;
            wr_dat <= 8'h00;
        end
        else
        begin
            wr_stb <= 1'b0;
            if (start_c)
            begin
                st_reg <= S_ADDR;
                bit_cnt <= 3'h0;
                byte_full <= 1'b0;
                cmd_seen <= 1'b0;
                smb_sdata_oe <= 1'b0;
            end
            else if (stop_c)
            begin
                st_reg <= S_IDLE;
                smb_sdata_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                case (st_reg)
                    S_ADDR, S_CMD, S_WDATA:
                    begin
                        sh_reg <= {sh_reg[6:0], sda_bit};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7)
                            byte_full <= 1'b1;
                    end
                    S_RDATA:
                        bit_cnt <= bit_cnt + 3'h1;
                    S_RACK:
                    begin
                        if (sda_bit)
                            st_reg <= S_WAIT;
                        else
                        begin
                            idx_reg <= idx_reg + 8'h01;
                            st_reg <= S_ACK;
                        end
                    end
                    default: ;
                endcase
            end
            else if (scl_fall)
            begin
                case (st_reg)
                    S_ADDR, S_CMD, S_WDATA:
                    begin
                        if (byte_full)
                        begin
                            byte_full <= 1'b0;
                            smb_sdata_oe <= 1'b1;
                            st_reg <= S_ACK;
                            if (st_reg == S_ADDR)
                            begin
                                read_mode <= sh_reg[0];
                                if (sh_reg[7:1] != SMB_ADDR)
                                begin
                                    smb_sdata_oe <= 1'b0;
                                    st_reg <= S_WAIT;
                                end
                            end
                            else if (st_reg == S_CMD)
                            begin
                                idx_reg <= sh_reg;
                                cmd_seen <= 1'b1;
                            end
                            else
                            begin
                                wr_stb <= 1'b1;
                                wr_idx <= idx_reg;
                                wr_dat <= sh_reg;
                                idx_reg <= idx_reg + 8'h01;
                            end
                        end
                    end
                    S_ACK:
                    begin
                        bit_cnt <= 3'h0;
                        if (read_mode)
                        begin
                            tx_reg <= rd_data;
                            smb_sdata_oe <= ~rd_data[7];
                            st_reg <= S_RDATA;
                        end
                        else
                        begin
                            smb_sdata_oe <= 1'b0;
                            st_reg <= cmd_seen ? S_WDATA : S_CMD;
                        end
                    end
                    S_RDATA:
                    begin
                        if (bit_cnt == 3'h0)
                        begin
                            smb_sdata_oe <= 1'b0;
                            st_reg <= S_RACK;
                        end
                        else
                        begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            smb_sdata_oe <= ~tx_reg[6];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

endmodule

// *** wfr_ctrl_sva.sv ***
// Port assertions for the watchdog recovery control block
`timescale 1ns/1ps
module wfr_ctrl_sva #(
    parameter RST_CYC = 64
) (
    input wire       ref_clk,
    input wire       rstn,
    input wire       smb_sdata_o,
    input wire       smb_sdata_oe,
    input wire [8:0] pll_fb_div,
    input wire [7:0] pll_ref_div,
    input wire       pll_use_nm,
    input wire       pll_load,
    input wire       sys_rst_n
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    reg [8:0] low_cnt;
    // Counts low cycles; a retrigger only lengthens the pulse
    always @(posedge ref_clk or negedge rstn)
        if (!rstn)
            low_cnt <= 9'h000;
        else
            low_cnt <= sys_rst_n ? 9'h000 : low_cnt + 9'h001;
    a_open_drain: assert property (smb_sdata_o == 1'b0)
        else $error("data pin driven high");
    a_ack_hold: assert property ($rose(smb_sdata_oe) |=> smb_sdata_oe[*4])
        else $error("ack too short");
    a_load_single: assert property (pll_load |=> !pll_load)
        else $error("load longer than one cycle");
    a_load_follows: assert property
        ($changed({pll_fb_div, pll_ref_div, pll_use_nm}) |-> pll_load)
        else $error("setting changed without load");
    a_load_settled: assert property
        (pll_load |=> $stable({pll_fb_div, pll_ref_div, pll_use_nm}))
        else $error("setting moved after load");
    a_div_range: assert property (pll_fb_div >= 9'h003 &&
        pll_fb_div <= 9'h102 && pll_ref_div >= 8'h03 && pll_ref_div <= 8'h82)
        else $error("divider outside N+3 or M+3 range");
    a_rst_width: assert property
        ($rose(sys_rst_n) |-> low_cnt >= RST_CYC)
        else $error("reset pulse too short");
    a_rst_cause: assert property ($fell(sys_rst_n) |->
        (pll_load || $past(pll_load) || $past(pll_load, 2))
        or (##[1:3] pll_load))
        else $error("reset pulse without change");
endmodule
bind wfr_watchdog_ctrl wfr_ctrl_sva #(.RST_CYC(RST_CYC)) u_sva (
    .ref_clk(ref_clk), .rstn(rstn), .smb_sdata_o(smb_sdata_o),
    .smb_sdata_oe(smb_sdata_oe), .pll_fb_div(pll_fb_div),
    .pll_ref_div(pll_ref_div), .pll_use_nm(pll_use_nm),
    .pll_load(pll_load), .sys_rst_n(sys_rst_n));

// *** wfr_smb_host.sv ***
// Serial bus host model for the register port
`timescale 1ns/1ps
`include "wfr_consts.vh"
module wfr_smb_host (
    input  wire sda_in,
    output reg  scl,
    output reg  sda_oe
);
    integer nacks;
    reg     r;
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
        nacks = 0;
    end
    // Clock stands high between frames; low 250 ns, high 150 ns
    task sbit(input b);
    begin
        sda_oe = ~b;
        #150 scl = 1'b1;
        #100 r = sda_in;
        #50 scl = 1'b0;
        #100;
    end
    endtask
    task start;
    begin
        sda_oe = 1'b0;
        #100 scl = 1'b1;
        #150 sda_oe = 1'b1;
        #100 scl = 1'b0;
        #100;
    end
    endtask
    task stop;
    begin
        sda_oe = 1'b1;
        #100 scl = 1'b1;
        #150 sda_oe = 1'b0;
        #200;
    end
    endtask
    task wbyte(input [7:0] v);
        integer i;
    begin
        for (i = 7; i >= 0; i = i - 1)
            sbit(v[i]);
        sbit(1'b1);
        if (r !== 1'b0)
            nacks = nacks + 1;
    end
    endtask
    // N and M go in one transaction; each byte still loads on its own
    task wr(input [7:0] idx, input [7:0] d0, input [7:0] d1, input two);
    begin
        start;
        wbyte({`WFR_SMB_ADDR, 1'b0});
        wbyte(idx);
        wbyte(d0);
        if (two)
            wbyte(d1);
        stop;
    end
    endtask
    task rd(input [7:0] idx, output [7:0] v);
        integer i;
    begin
        start;
        wbyte({`WFR_SMB_ADDR, 1'b0});
        wbyte(idx);
        start;
        wbyte({`WFR_SMB_ADDR, 1'b1});
        for (i = 7; i >= 0; i = i - 1)
        begin
            sbit(1'b1);
            v[i] = r;
        end
        sbit(1'b1);
        stop;
    end
    endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the watchdog recovery control block
`timescale 1ns/1ps
module testbench;
    reg        ref_clk;
    reg        rstn;
    reg  [4:0] strap;
    wire       scl;
    wire       h_oe;
    wire       d_oe;
    wire       sda;
    wire [8:0] fb;
    wire [7:0] rf;
    wire [4:0] code;
    wire       use_nm;
    wire       load;
    wire       srst_n;
    integer    fail_count;
    integer    n_compared;
    integer    falls;
    integer    cyc;
    reg  [7:0] d;
    // Pulled-up open-drain data line
    assign sda = ~(h_oe | d_oe);
    wfr_watchdog_ctrl #(.SHORT_CYC(20), .LONG_CYC(50), .RST_CYC(8)) u_dut (
        .ref_clk(ref_clk), .rstn(rstn), .smb_sclk(scl), .smb_sdata_i(sda),
        .smb_sdata_o(), .smb_sdata_oe(d_oe), .strap_speed_code(strap),
        .pll_fb_div(fb), .pll_ref_div(rf), .pll_speed_code(code),
        .pll_use_nm(use_nm), .pll_load(load), .sys_rst_n(srst_n));
    wfr_smb_host u_host (.sda_in(sda), .scl(scl), .sda_oe(h_oe));
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(negedge srst_n)
        falls = falls + 1;
    task results;
    begin
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    task chk(input [8:0] g, input [8:0] e);
    begin
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            fail_count = fail_count + 1;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    end
    endtask
    task w1(input [7:0] i, input [7:0] v);
        u_host.wr(i, v, 8'h00, 1'b0);
    endtask
    task rchk(input [7:0] i, input [8:0] e);
    begin
        u_host.rd(i, d);
        chk({1'b0, d}, e);
    end
    endtask
    // Bounded wait for a load pulse or a reset pulse
    task wait_evt(input on_rst);
    begin
        cyc = 0;
        while (cyc < 300 && (on_rst ? srst_n !== 1'b0 : load !== 1'b1))
        begin
            @(posedge ref_clk);
            #1 cyc = cyc + 1;
        end
        if (cyc == 300)
        begin
            fail_count = fail_count + 1;
            $display("Error %0t: event never came", $time);
            results;
        end
    end
    endtask
    initial
    begin
        fail_count = 0;
        n_compared = 0;
        falls = 0;
        rstn = 1'b0;
        strap = 5'h13;
        repeat (5) @(posedge ref_clk);
        #1 rstn = 1'b1;
        repeat (6) @(posedge ref_clk);
        chk(fb, 9'h003);
        w1(8'h09, 8'h55);
        w1(8'h08, 8'hff);
        rchk(8'h04, 9'h000);
        rchk(8'h08, 9'h000);
        rchk(8'h09, 9'h000);
        $display("reset and access test done");
        w1(8'h00, 8'h01);
        u_host.wr(8'h02, 8'h61, 8'h5d, 1'b1);
        chk(fb, 9'h064);
        chk(rf, 9'h060);
        chk(use_nm, 9'h001);
        $display("programmable test done");
        u_host.wr(8'h06, 8'hc8, 8'h30, 1'b1);
        w1(8'h05, 8'h02);
        w1(8'h04, 8'h13);
        w1(8'h00, 8'h01);
        wait_evt(1'b1);
        chk(cyc >= 30 && cyc <= 58, 9'h001);
        repeat (3) @(posedge ref_clk);
        chk(fb, 9'h0cb);
        chk(rf, 9'h033);
        chk(falls, 9'h001);
        rchk(8'h04, 9'h057);
        w1(8'h04, 8'h13);
        rchk(8'h04, 9'h057);
        w1(8'h04, 8'h15);
        rchk(8'h04, 9'h051);
        w1(8'h06, 8'h64);
        chk(fb, 9'h067);
        $display("recovery from N and M test done");
        w1(8'h04, 8'h0a);
        chk(fb, 9'h064);
        w1(8'h05, 8'h00);
        w1(8'h01, 8'h05);
        wait_evt(1'b0);
        chk(cyc >= 20 && cyc <= 45, 9'h001);
        repeat (3) @(posedge ref_clk);
        chk(use_nm, 9'h000);
        chk(code, 9'h013);
        chk(falls, 9'h001);
        rchk(8'h04, 9'h04e);
        $display("strap recovery test done");
        w1(8'h05, 8'h1f);
        w1(8'h00, 8'h01);
        w1(8'h04, 8'h08);
        rchk(8'h08, 9'h01f);
        w1(8'h04, 8'h0a);
        rchk(8'h08, 9'h01f);
        $display("enable test done");
        w1(8'h04, 8'h20);
        w1(8'h00, 8'h02);
        repeat (3) @(posedge ref_clk);
        chk(use_nm, 9'h000);
        chk(code, 9'h005);
        chk(falls, 9'h002);
        chk(u_host.nacks, 9'h000);
        $display("frequency change reset test done");
        results;
    end
endmodule
